//--- logic/dac_slave_pkg.sv
// Package with constants shared by the two-wire DAC slave design files.
package dac_slave_pkg;
   localparam int CODE_W = 12;
   localparam logic [5:0] PREFIX_VARIANT_L = 6'h1C;
   localparam logic [5:0] PREFIX_VARIANT_M = 6'h2C;
   localparam logic [3:0] CMD_LOAD_A_UPD = 4'h0;
   localparam logic [3:0] CMD_LOAD_B_UPD = 4'h1;
   localparam logic [3:0] CMD_IN_A = 4'h4;
   localparam logic [3:0] CMD_IN_B = 4'h5;
   localparam logic [3:0] CMD_UPD_IN_A = 4'h8;
   localparam logic [3:0] CMD_UPD_IN_B = 4'h9;
   localparam logic [3:0] CMD_LOAD_ALL = 4'hC;
   localparam logic [3:0] CMD_IN_ALL = 4'hD;
   localparam logic [3:0] CMD_UPDATE = 4'hE;
   localparam logic [3:0] CMD_EXT = 4'hF;
   localparam logic [3:0] SUB_EXT = 4'h0;
   localparam logic [3:0] SUB_READ_A = 4'h1;
   localparam logic [3:0] SUB_READ_B = 4'h2;
   localparam logic [1:0] PD_POWER_UP = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_1K = 2'h2;
   localparam logic [1:0] PD_100K = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Extended byte layout: channel A select, channel B select, mode bits.
   localparam int EXT_SEL_A = 3;
   localparam int EXT_SEL_B = 2;
   localparam int EXT_PD_HI = 1;
   localparam int EXT_PD_LO = 0;
endpackage

//--- logic/sync_two_ff.sv
// Two flip-flop synchroniser for signals from outside the clock domain.
`timescale 1ns/1ps
module sync_two_ff #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic asyncIn,
   output logic syncOut
);
   typedef struct packed {
      logic first;
      logic second;
   } sync_state_type;
   sync_state_type state;
   sync_state_type next_state;

   // The first stage feeds only the second stage.
   always_comb begin
      next_state.first = asyncIn;
      next_state.second = state.first;
   end

   // Both stages reset to RESET_LEVEL, which defaults to the idle (high) bus level.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= {RESET_LEVEL, RESET_LEVEL};
      end else begin
         state <= next_state;
      end
   end

   assign syncOut = state.second;
endmodule

//--- logic/bus_edge_detect.sv
// Edge and START/STOP detector for the synchronised two-wire bus lines.
`timescale 1ns/1ps
module bus_edge_detect (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclSync,
   input wire logic sdaSync,
   output logic sclRise,
   output logic sclFall,
   output logic startSeen,
   output logic stopSeen
);
   typedef struct packed {
      logic sclLast;
      logic sdaLast;
   } edge_state_type;
   edge_state_type state;
   edge_state_type next_state;

   // Remember the previous sample of each line.
   always_comb begin
      next_state.sclLast = sclSync;
      next_state.sdaLast = sdaSync;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{sclLast: 1'b1, sdaLast: 1'b1};
      end else begin
         state <= next_state;
      end
   end

   // Data changing while the clock is high marks START or STOP.
   assign sclRise = sclSync & ~state.sclLast;
   assign sclFall = ~sclSync & state.sclLast;
   assign startSeen = sclSync & state.sclLast & state.sdaLast & ~sdaSync;
   assign stopSeen = sclSync & state.sclLast & ~state.sdaLast & sdaSync;
endmodule

//--- logic/dual_dac_i2c_command_slave.sv
// Two-wire command slave that holds the registers of a dual 12-bit DAC.
`timescale 1ns/1ps
module dual_dac_i2c_command_slave #(
   parameter logic [5:0] ADDR_PREFIX = dac_slave_pkg::PREFIX_VARIANT_L
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic address_lsb_strap,
   output logic [11:0] dacCodeA,
   output logic [11:0] dacCodeB,
   output logic [1:0] powerdownA,
   output logic [1:0] powerdownB,
   output logic [11:0] inputCodeA,
   output logic [11:0] inputCodeB
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WRITE = 7'h08,
      ST_WRITE_ACK = 7'h10,
      ST_READ = 7'h20,
      ST_READ_ACK = 7'h40
   } phase_type;

   typedef struct packed {
      phase_type phase;
      logic [3:0] bitCount;
      logic [7:0] shift;
      logic [1:0] byteCount;
      logic isRead;
      logic [3:0] command_nibble;
      logic [3:0] subNibble;
      logic [11:0] inA;
      logic [11:0] inB;
      logic [11:0] dacA;
      logic [11:0] dacB;
      logic [1:0] pdA;
      logic [1:0] pdB;
      logic readSelB;
      logic drive;
      logic [6:0] myAddr;
   } slave_state_type;

   slave_state_type state;
   slave_state_type next_state;
   logic sclSync;
   logic sdaSync;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;

   sync_two_ff syncScl (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(sclIn),
      .syncOut(sclSync)
   );
   sync_two_ff syncSda (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(sdaIn),
      .syncOut(sdaSync)
   );
   logic strapSync;
   sync_two_ff #(.RESET_LEVEL(1'b0)) syncStrap (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(address_lsb_strap),
      .syncOut(strapSync)
   );
   bus_edge_detect edges (
      .core_clk(core_clk),
      .rst(rst),
      .sclSync(sclSync),
      .sdaSync(sdaSync),
      .sclRise(sclRise),
      .sclFall(sclFall),
      .startSeen(startSeen),
      .stopSeen(stopSeen)
   );

   // Picks the read-back byte: upper four bits first, then lower eight.
   function automatic logic [7:0] readByte(input logic [11:0] code,
                                           input logic [1:0] idx);
      if (idx == 2'h0) begin
         readByte = {4'h0, code[11:8]};
      end else begin
         readByte = code[7:0];
      end
   endfunction

   // Bus protocol and command execution.
   always_comb begin
      logic [7:0] rx;
      logic [11:0] code;
      logic [7:0] firstByte;
      rx = {state.shift[6:0], sdaSync};
      firstByte = readByte(state.readSelB ? state.dacB : state.dacA, 2'h0);
      code = {state.command_nibble == dac_slave_pkg::CMD_EXT ?
              state.subNibble : state.subNibble, state.shift};
      next_state = state;
      // Address prefix fixed, LSB from strap, latched continuously.
      next_state.myAddr = {ADDR_PREFIX, strapSync};
      if (startSeen) begin
         // START reconnects the core; any half-done write is dropped.
         next_state.phase = ST_ADDR;
         next_state.bitCount = 4'h0;
         next_state.drive = 1'b0;
         next_state.byteCount = 2'h0;
      end else if (stopSeen) begin
         next_state.phase = ST_IDLE;
         next_state.drive = 1'b0;
      end else begin
         case (state.phase)
            ST_IDLE: begin
               next_state.drive = 1'b0;
            end
            ST_ADDR: begin
               if (sclRise) begin
                  next_state.shift = rx;
                  next_state.bitCount = state.bitCount + 4'h1;
                  if (state.bitCount != dac_slave_pkg::BIT_LAST &&
                      sdaSync != state.myAddr[3'h6 -
                                 state.bitCount[2:0]]) begin
                     // First differing bit ends participation.
                     next_state.phase = ST_IDLE;
                  end
               end else if (sclFall &&
                            state.bitCount == dac_slave_pkg::BIT_ACK) begin
                  next_state.isRead = state.shift[0];
                  next_state.drive = 1'b1;
                  next_state.phase = ST_ADDR_ACK;
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  next_state.bitCount = 4'h0;
                  if (state.isRead) begin
                     next_state.byteCount = 2'h0;
                     next_state.drive = ~firstByte[7];
                     next_state.shift = firstByte << 1;
                     next_state.phase = ST_READ;
                  end else begin
                     next_state.drive = 1'b0;
                     next_state.phase = ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               if (sclRise) begin
                  next_state.shift = rx;
                  next_state.bitCount = state.bitCount + 4'h1;
               end else if (sclFall &&
                            state.bitCount == dac_slave_pkg::BIT_ACK) begin
                  next_state.drive = 1'b1;
                  next_state.phase = ST_WRITE_ACK;
               end
            end
            ST_WRITE_ACK: begin
               if (sclFall) begin
                  next_state.drive = 1'b0;
                  next_state.bitCount = 4'h0;
                  next_state.phase = ST_WRITE;
                  next_state.byteCount = state.byteCount + 2'h1;
                  if (state.byteCount == 2'h0) begin
                     next_state.command_nibble = state.shift[7:4];
                     next_state.subNibble = state.shift[3:0];
                     if (state.shift[7:4] == dac_slave_pkg::CMD_UPDATE) begin
                        next_state.dacA = state.inA;
                        next_state.dacB = state.inB;
                        next_state.byteCount = 2'h0;
                     end else if (state.shift[7:4] ==
                                  dac_slave_pkg::CMD_EXT) begin
                        if (state.shift[3:0] ==
                            dac_slave_pkg::SUB_READ_A) begin
                           next_state.readSelB = 1'b0;
                           next_state.byteCount = 2'h0;
                        end else if (state.shift[3:0] ==
                                     dac_slave_pkg::SUB_READ_B) begin
                           next_state.readSelB = 1'b1;
                           next_state.byteCount = 2'h0;
                        end else if (state.shift[3:0] !=
                                     dac_slave_pkg::SUB_EXT) begin
                           next_state.byteCount = 2'h0;
                        end
                     end
                  end else begin
                     // Second byte completes the write: apply on this edge.
                     next_state.byteCount = 2'h0;
                     if (state.command_nibble == dac_slave_pkg::CMD_EXT) begin
                        // Mode codes persist; registers keep contents.
                        if (state.shift[dac_slave_pkg::EXT_SEL_A]) begin
                           next_state.pdA = {
                              state.shift[dac_slave_pkg::EXT_PD_HI],
                              state.shift[dac_slave_pkg::EXT_PD_LO]};
                        end
                        if (state.shift[dac_slave_pkg::EXT_SEL_B]) begin
                           next_state.pdB = {
                              state.shift[dac_slave_pkg::EXT_PD_HI],
                              state.shift[dac_slave_pkg::EXT_PD_LO]};
                        end
                     end else begin
                        case (state.command_nibble)
                           dac_slave_pkg::CMD_LOAD_A_UPD: begin
                              next_state.inA = code;
                              next_state.dacA = code;
                              next_state.dacB = state.inB;
                           end
                           dac_slave_pkg::CMD_LOAD_B_UPD: begin
                              next_state.inB = code;
                              next_state.dacB = code;
                              next_state.dacA = state.inA;
                           end
                           dac_slave_pkg::CMD_IN_A: begin
                              next_state.inA = code;
                           end
                           dac_slave_pkg::CMD_IN_B: begin
                              next_state.inB = code;
                           end
                           dac_slave_pkg::CMD_UPD_IN_A: begin
                              next_state.dacA = state.inA;
                              next_state.dacB = state.inB;
                              next_state.inA = code;
                           end
                           dac_slave_pkg::CMD_UPD_IN_B: begin
                              next_state.dacA = state.inA;
                              next_state.dacB = state.inB;
                              next_state.inB = code;
                           end
                           dac_slave_pkg::CMD_LOAD_ALL: begin
                              next_state.inA = code;
                              next_state.inB = code;
                              next_state.dacA = code;
                              next_state.dacB = code;
                           end
                           dac_slave_pkg::CMD_IN_ALL: begin
                              next_state.inA = code;
                              next_state.inB = code;
                           end
                           default: begin
                              next_state.byteCount = 2'h0;
                           end
                        endcase
                     end
                  end
               end
            end
            ST_READ: begin
               if (sclFall) begin
                  next_state.bitCount = state.bitCount + 4'h1;
                  if (state.bitCount == dac_slave_pkg::BIT_LAST) begin
                     next_state.drive = 1'b0; // release for master ack
                     next_state.phase = ST_READ_ACK;
                  end else begin
                     next_state.drive = ~state.shift[7];
                     next_state.shift = state.shift << 1;
                  end
               end
            end
            ST_READ_ACK: begin
               if (sclRise) begin
                  next_state.shift = readByte(state.readSelB ?
                     state.dacB : state.dacA, 2'h1);
                  if (sdaSync || state.byteCount != 2'h0) begin
                     next_state.phase = ST_IDLE; // master done
                  end
               end else if (sclFall) begin
                  next_state.byteCount = 2'h1;
                  next_state.bitCount = 4'h0;
                  next_state.drive = ~state.shift[7];
                  next_state.shift = state.shift << 1;
                  next_state.phase = ST_READ;
               end
            end
            default: begin
               next_state.phase = ST_IDLE;
            end
         endcase
      end
   end

   // Power-on defaults: zero codes, both channels in 100k power-down.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
         state.phase <= ST_IDLE;
         state.pdA <= dac_slave_pkg::PD_100K;
         state.pdB <= dac_slave_pkg::PD_100K;
      end else begin
         state <= next_state;
      end
   end

   // Outputs come straight from the state register, except sdaOut, which is tied low.
   assign sdaOut = 1'b0;
   assign sdaOe = state.drive;
   assign dacCodeA = state.dacA;
   assign dacCodeB = state.dacB;
   assign inputCodeA = state.inA;
   assign inputCodeB = state.inB;
   assign powerdownA = state.pdA;
   assign powerdownB = state.pdB;

   a_reset_pd: assert property (@(posedge core_clk)
      $fell(rst) |-> powerdownA == dac_slave_pkg::PD_100K)
      else $error("Power-down default wrong after reset.");
   a_mismatch_quiet: assert property (@(posedge core_clk) disable iff (rst)
      state.phase == ST_IDLE && !startSeen |=> !sdaOe)
      else $error("Data line driven while disconnected.");
   a_ack_on_match: assert property (@(posedge core_clk) disable iff (rst)
      state.phase == ST_ADDR_ACK |-> sdaOe)
      else $error("Address acknowledge missing.");
   a_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
      stopSeen |=> state.phase == ST_IDLE)
      else $error("Stop did not end the transfer.");
   a_dac_write_ack: assert property (@(posedge core_clk) disable iff (rst)
      $changed(dacCodeA) |-> $past(state.phase) == ST_WRITE_ACK)
      else $error("DAC register changed outside the ack edge.");
   a_in_hold: assert property (@(posedge core_clk) disable iff (rst)
      $changed(inputCodeB) |-> $past(sclFall))
      else $error("Input register changed off a falling clock.");
   a_start_addr: assert property (@(posedge core_clk) disable iff (rst)
      startSeen |=> state.phase == ST_ADDR && state.bitCount == 4'h0)
      else $error("Start did not begin address phase.");
   a_pd_change: assert property (@(posedge core_clk) disable iff (rst)
      $changed(powerdownB) |-> $past(state.command_nibble) ==
      dac_slave_pkg::CMD_EXT)
      else $error("Power-down changed without extended command.");
endmodule

//--- verif/i2c_master_model.sv
// Behavioural two-wire bus master that drives the DAC slave.
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic core_clk,
   input wire logic sdaOe,
   output logic sclIn,
   output logic sdaIn
);
   logic sdaDrive = 1'b1;
   // The pull-up wins unless either party pulls the data line low.
   assign sdaIn = sdaDrive & ~sdaOe;
   // The clock stands high outside frames.
   initial sclIn = 1'b1;
   // Waits a number of core clock cycles.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One bit slot of eight cycles, sampled late in the high phase.
   task automatic putBit(input logic b, output logic seen);
      tick(3);
      sdaDrive <= b;
      tick(2);
      sclIn <= 1'b1;
      tick(2);
      seen = sdaIn;
      tick(1);
      sclIn <= 1'b0;
   endtask
   // Start, also used as repeated start for a read-back.
   task automatic startCond();
      tick(3);
      sdaDrive <= 1'b1;
      tick(2);
      sclIn <= 1'b1;
      tick(2);
      sdaDrive <= 1'b0;
      tick(2);
      sclIn <= 1'b0;
   endtask
   // Stop ends a frame and leaves both lines high.
   task automatic stopCond();
      tick(3);
      sdaDrive <= 1'b0;
      tick(2);
      sclIn <= 1'b1;
      tick(2);
      sdaDrive <= 1'b1;
      tick(3);
   endtask
   // Sends a byte most significant bit first and returns the acknowledge.
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) putBit(b[i], s);
      putBit(1'b1, s);
      ack = ~s;
   endtask
   // Reads a byte, then acknowledges it or not.
   task automatic readByte(input logic ackIt, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) putBit(1'b1, v[i]);
      putBit(~ackIt, s);
   endtask
endmodule

//--- verif/dual_dac_i2c_command_slave_test.sv
// Self-checking bench for the two-wire dual DAC command slave.
`timescale 1ns/1ps
module dual_dac_i2c_command_slave_test;
   localparam logic [5:0] PRE = dac_slave_pkg::PREFIX_VARIANT_L;
   localparam int LIMIT = 20000;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic sclIn, sdaIn, sdaOut, sdaOe, ack;
   logic [11:0] dacCodeA, dacCodeB, inputCodeA, inputCodeB;
   logic [1:0] powerdownA, powerdownB;
   logic [11:0] expDacA = 12'h000, expDacB = 12'h000;
   logic [11:0] expInA = 12'h000, expInB = 12'h000;
   logic [1:0] expPdA = 2'h3, expPdB = 2'h3;
   logic [3:0] cmdList [10] = '{4'hC, 4'h4, 4'h5, 4'hE, 4'h8, 4'h9, 4'h0,
      4'h1, 4'hD, 4'h2};
   logic [3:0] extList [5] = '{4'h8, 4'h5, 4'hE, 4'hF, 4'hC};
   logic [7:0] badList [4] = '{{PRE, 2'b00}, 8'h58, 8'h00, 8'hF0};
   int errors = 0, check_count = 0, cycles = 0;

   dual_dac_i2c_command_slave #(.ADDR_PREFIX(PRE))
      u_dual_dac_i2c_command_slave (
      .core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .address_lsb_strap(strap),
      .dacCodeA(dacCodeA), .dacCodeB(dacCodeB), .powerdownA(powerdownA),
      .powerdownB(powerdownB), .inputCodeA(inputCodeA),
      .inputCodeB(inputCodeB));

   i2c_master_model u_i2c_master_model (
      .core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

   // The core clock runs at 10 MHz.
   always #50 core_clk = ~core_clk;

   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Compares one value and counts the result.
   task automatic checkVal(input logic [11:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Compares every register output with the expected state.
   task automatic checkState();
      checkVal(dacCodeA, expDacA, "dacA");
      checkVal(dacCodeB, expDacB, "dacB");
      checkVal(inputCodeA, expInA, "inA");
      checkVal(inputCodeB, expInB, "inB");
      checkVal({10'h000, powerdownA}, {10'h000, expPdA}, "pdA");
      checkVal({10'h000, powerdownB}, {10'h000, expPdB}, "pdB");
      checkVal({11'h000, sdaOut}, 12'h000, "sdaOut");
   endtask

   // Works out the expected registers after a complete write.
   task automatic model(input logic [3:0] cmd, input logic [11:0] code);
      case (cmd)
         4'h0: {expInA, expDacA, expDacB} = {code, code, expInB};
         4'h1: {expInB, expDacB, expDacA} = {code, code, expInA};
         4'h4: expInA = code;
         4'h5: expInB = code;
         4'h8: {expDacA, expDacB, expInA} = {expInA, expInB, code};
         4'h9: {expDacA, expDacB, expInB} = {expInA, expInB, code};
         4'hC: {expInA, expInB, expDacA, expDacB} = {4{code}};
         4'hD: {expInA, expInB} = {2{code}};
         4'hE: {expDacA, expDacB} = {expInA, expInB};
         4'hF: begin
            if (code[11:8] == 4'h0 && code[3]) expPdA = code[1:0];
            if (code[11:8] == 4'h0 && code[2]) expPdB = code[1:0];
         end
         default: ;
      endcase
   endtask

   // One write frame; a cut frame stops before the second data byte.
   task automatic doCmd(input logic [3:0] cmd, input logic [11:0] code,
         input logic cut);
      u_i2c_master_model.startCond();
      u_i2c_master_model.sendByte({PRE, strap, 1'b0}, ack);
      checkVal({11'h000, ack}, 12'h001, "addr ack");
      u_i2c_master_model.sendByte({cmd, code[11:8]}, ack);
      checkVal({11'h000, ack}, 12'h001, "cmd ack");
      if (cmd != dac_slave_pkg::CMD_UPDATE && !cut)
         u_i2c_master_model.sendByte(code[7:0], ack);
      u_i2c_master_model.stopCond();
      if (!cut)
         model(cmd, code);
      checkState();
   endtask

   // Selects a channel, turns the bus round and reads its DAC register.
   task automatic readBack(input logic ch);
      logic [7:0] hi, lo;
      logic [11:0] exp;
      exp = ch ? expDacB : expDacA;
      u_i2c_master_model.startCond();
      u_i2c_master_model.sendByte({PRE, strap, 1'b0}, ack);
      u_i2c_master_model.sendByte({4'hF, 2'b00, ch, ~ch}, ack);
      u_i2c_master_model.startCond();
      u_i2c_master_model.sendByte({PRE, strap, 1'b1}, ack);
      checkVal({11'h000, ack}, 12'h001, "read ack");
      u_i2c_master_model.readByte(1'b1, hi);
      u_i2c_master_model.readByte(1'b0, lo);
      u_i2c_master_model.stopCond();
      checkVal({4'h0, hi}, {8'h00, exp[11:8]}, "read hi");
      checkVal({4'h0, lo}, {4'h0, exp[7:0]}, "read lo");
   endtask

   // A foreign address gets no acknowledge and changes nothing.
   task automatic badAddr(input logic [7:0] a);
      u_i2c_master_model.startCond();
      u_i2c_master_model.sendByte(a, ack);
      checkVal({11'h000, ack}, 12'h000, "bad ack");
      u_i2c_master_model.sendByte(8'hCF, ack);
      u_i2c_master_model.sendByte(8'hFF, ack);
      u_i2c_master_model.stopCond();
      checkState();
   endtask

   // Main sequence of reset, writes, power-down, read-back and addressing.
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      checkState();
      for (int i = 0; i < 10; i++)
         doCmd(cmdList[i], 12'h0F1 * 12'(i + 1), 1'b0);
      doCmd(4'hC, 12'h5A5, 1'b1);
      for (int i = 0; i < 5; i++)
         doCmd(4'hF, {8'h00, extList[i]}, 1'b0);
      readBack(1'b0);
      readBack(1'b1);
      @(posedge core_clk);
      strap <= 1'b1;
      repeat (4) @(posedge core_clk);
      doCmd(4'hC, 12'h3C5, 1'b0);
      for (int i = 0; i < 4; i++)
         badAddr(badList[i]);
      doCmd(4'h4, 12'h0AA, 1'b0);
      complete_run();
   end

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         $display("[FAIL] %0t timeout", $time);
         complete_run();
      end
   end
endmodule
